// ==== src/idle_color_format_lvd_cmds.sv ====
// Command interpreter for idle mode, pixel format and voltage detect.
`timescale 1ns/1ps
module idle_color_format_lvd_cmds
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Command port, pins taken as synchronous
	input wire logic cmdParamSelect,
	input wire logic write_strobe_n,
	input wire logic [7:0] dataIn,
	// Timing generator
	input wire logic frameStart,
	input wire logic [7:0] normalRateSetting,
	input wire logic [7:0] idleRateSetting,
	output logic [7:0] frameRateSetting,
	output logic idleActive,
	// Host pixel write path
	input wire logic pixelInValid,
	input wire logic [17:0] pixelInData,
	output logic memWriteValid,
	output idle_fmt_pkg::pixel_t memWriteData,
	// Display scan path
	input wire logic scanValid,
	input wire idle_fmt_pkg::pixel_t scanPixel,
	output logic panelValid,
	output idle_fmt_pkg::pixel_t panelPixel,
	// Configuration outputs
	output logic [7:0] pixelFormat,
	output logic [3:0] videoFormat,
	output logic [2:0] controlFormat,
	output idle_fmt_pkg::fmt_info_t videoInfo,
	output idle_fmt_pkg::fmt_info_t controlInfo,
	output logic [7:0] lvdThreshold,
	output logic [11:0] lvdMillivolts,
	output logic unlocked
);

	idle_fmt_pkg::cmd_state_t state;
	logic strobePrev;
	logic writeTaken;
	logic cmdTaken;
	logic paramTaken;
	logic swReset;
	logic idleRequest;
	logic [17:0] scanBits;
	logic [17:0] reducedBits;

	// A write lands on the rising edge of the active-low strobe
	assign writeTaken = write_strobe_n && !strobePrev;
	assign cmdTaken = writeTaken && !cmdParamSelect;
	assign paramTaken = writeTaken && cmdParamSelect;
	// No state gates acceptance, so sleep and partial modes take these too
	assign swReset = cmdTaken && (dataIn == idle_fmt_pkg::CMD_SW_RESET);

	// Strobe history for edge detection
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strobePrev <= 1'b1;
		end
		else
		begin
			strobePrev <= write_strobe_n;
		end
	end

	// Which parameter the next data byte belongs to
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= idle_fmt_pkg::ST_READY;
		end
		else if (cmdTaken)
		begin
			case (dataIn)
				idle_fmt_pkg::CMD_PIXEL_FORMAT: state <= idle_fmt_pkg::ST_WAIT_FORMAT;
				idle_fmt_pkg::CMD_LVD: state <= idle_fmt_pkg::ST_WAIT_LVD;
				idle_fmt_pkg::CMD_UNLOCK: state <= idle_fmt_pkg::ST_WAIT_KEY;
				default: state <= idle_fmt_pkg::ST_READY;
			endcase
		end
		else if (paramTaken)
		begin
			// Each of these commands takes exactly one byte
			state <= idle_fmt_pkg::ST_READY;
		end
	end

	// Requested idle mode; repeats of the same command are harmless
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idleRequest <= idle_fmt_pkg::IDLE_RESET;
		end
		else if (swReset)
		begin
			idleRequest <= idle_fmt_pkg::IDLE_RESET;
		end
		else if (cmdTaken && dataIn == idle_fmt_pkg::CMD_IDLE_OFF)
		begin
			idleRequest <= 1'b0;
		end
		else if (cmdTaken && dataIn == idle_fmt_pkg::CMD_IDLE_ON)
		begin
			idleRequest <= 1'b1;
		end
	end

	// Applied only at a frame boundary so no frame mixes both modes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idleActive <= idle_fmt_pkg::IDLE_RESET;
			frameRateSetting <= '0;
		end
		else if (frameStart)
		begin
			idleActive <= idleRequest;
			if (idleRequest)
			begin
				frameRateSetting <= idleRateSetting;
			end
			else
			begin
				frameRateSetting <= normalRateSetting;
			end
		end
	end

	// Interface pixel format byte
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pixelFormat <= idle_fmt_pkg::PIXEL_FORMAT_RESET;
		end
		else if (swReset)
		begin
			pixelFormat <= idle_fmt_pkg::PIXEL_FORMAT_RESET;
		end
		else if (paramTaken && state == idle_fmt_pkg::ST_WAIT_FORMAT)
		begin
			// Bit 3 is kept zero whatever the host sends
			pixelFormat <= {dataIn[7:4], 1'b0, dataIn[2:0]};
		end
	end

	assign videoFormat = pixelFormat[idle_fmt_pkg::VIDEO_FMT_MSB:
		idle_fmt_pkg::VIDEO_FMT_LSB];
	assign controlFormat = pixelFormat[idle_fmt_pkg::CTRL_FMT_MSB:
		idle_fmt_pkg::CTRL_FMT_LSB];

	// Video port format decode
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			videoInfo <= '0;
		end
		else
		begin
			case (videoFormat)
				idle_fmt_pkg::VID_16_ONE: videoInfo <= {1'b1, 5'h10, 2'h1};
				idle_fmt_pkg::VID_18_ONE: videoInfo <= {1'b1, 5'h12, 2'h1};
				idle_fmt_pkg::VID_18_THREE: videoInfo <= {1'b1, 5'h12, 2'h3};
				default: videoInfo <= '0;
			endcase
		end
	end

	// Control port format decode
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			controlInfo <= '0;
		end
		else
		begin
			case (controlFormat)
				idle_fmt_pkg::CTL_12: controlInfo <= {1'b1, 5'h0c, 2'h1};
				idle_fmt_pkg::CTL_16: controlInfo <= {1'b1, 5'h10, 2'h1};
				idle_fmt_pkg::CTL_18: controlInfo <= {1'b1, 5'h12, 2'h1};
				default: controlInfo <= '0;
			endcase
		end
	end

	// Unlock key; any other key value locks again
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			unlocked <= 1'b0;
		end
		else if (swReset)
		begin
			unlocked <= 1'b0;
		end
		else if (paramTaken && state == idle_fmt_pkg::ST_WAIT_KEY)
		begin
			unlocked <= (dataIn == idle_fmt_pkg::UNLOCK_KEY);
		end
	end

	// Detect threshold byte; ignored while locked
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lvdThreshold <= idle_fmt_pkg::LVD_RESET;
		end
		else if (swReset)
		begin
			lvdThreshold <= idle_fmt_pkg::LVD_RESET;
		end
		else if (paramTaken && state == idle_fmt_pkg::ST_WAIT_LVD && unlocked)
		begin
			lvdThreshold <= {6'h00, dataIn[idle_fmt_pkg::LVD_SEL_MSB:
				idle_fmt_pkg::LVD_SEL_LSB]};
		end
	end

	// Threshold in millivolts for the analog trim
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lvdMillivolts <= idle_fmt_pkg::LVD_MV_10;
		end
		else
		begin
			case (lvdThreshold[1:0])
				2'h0: lvdMillivolts <= idle_fmt_pkg::LVD_MV_00;
				2'h1: lvdMillivolts <= idle_fmt_pkg::LVD_MV_01;
				2'h2: lvdMillivolts <= idle_fmt_pkg::LVD_MV_10;
				default: lvdMillivolts <= idle_fmt_pkg::LVD_MV_11;
			endcase
		end
	end

	// Host pixels widened before they reach memory
	pixel_expand u_expand
	(
		.clk(clk),
		.rst_n(rst_n),
		.inValid(pixelInValid),
		.inData(pixelInData),
		.controlFormat(controlFormat),
		.outValid(memWriteValid),
		.outPixel(memWriteData)
	);

	// Each channel becomes all ones or all zeros from its MSB
	assign scanBits = scanPixel;
	genvar ch;
	generate
		for (ch = 0; ch < idle_fmt_pkg::CHANNELS; ch++)
		begin : g_reduce
			assign reducedBits[ch*6 +: 6] = {6{scanBits[ch*6+5]}};
		end
	endgenerate

	// Registered so the panel sees one mode per frame
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			panelValid <= 1'b0;
			panelPixel <= '0;
		end
		else
		begin
			panelValid <= scanValid;
			if (scanValid)
			begin
				panelPixel <= idleActive ? reducedBits : scanPixel;
			end
		end
	end

	sequence s_sw_reset;
		swReset;
	endsequence
	sequence s_idle_off_cmd;
		cmdTaken && dataIn == idle_fmt_pkg::CMD_IDLE_OFF;
	endsequence
	sequence s_idle_on_cmd;
		cmdTaken && dataIn == idle_fmt_pkg::CMD_IDLE_ON;
	endsequence
	sequence s_frame_edge;
		frameStart ##1 1'b1;
	endsequence

	a_idle_off_cmd: assert property (@(posedge clk) disable iff (!rst_n)
		s_idle_off_cmd |=> !idleRequest)
		else $error("idle off command ignored");
	a_idle_on_cmd: assert property (@(posedge clk) disable iff (!rst_n)
		s_idle_on_cmd |=> idleRequest)
		else $error("idle on command ignored");
	a_idle_only_cmds: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(idleRequest) |-> $past(cmdTaken) &&
			($past(dataIn) == idle_fmt_pkg::CMD_IDLE_OFF ||
			$past(dataIn) == idle_fmt_pkg::CMD_IDLE_ON ||
			$past(dataIn) == idle_fmt_pkg::CMD_SW_RESET))
		else $error("idle request moved without a command");
	a_repeat_on: assert property (@(posedge clk) disable iff (!rst_n)
		(s_idle_on_cmd ##0 idleRequest) |=> idleRequest && $stable(pixelFormat))
		else $error("repeated idle on changed state");
	a_idle_frame_sync: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(idleActive) |-> $past(frameStart))
		else $error("idle mode changed inside a frame");
	a_frame_applies: assert property (@(posedge clk) disable iff (!rst_n)
		s_frame_edge |-> idleActive == $past(idleRequest))
		else $error("frame start did not apply idle request");
	a_rate_normal: assert property (@(posedge clk) disable iff (!rst_n)
		(frameStart && !idleRequest) |=>
			frameRateSetting == $past(normalRateSetting))
		else $error("normal frame rate not applied");
	a_rate_idle: assert property (@(posedge clk) disable iff (!rst_n)
		(frameStart && idleRequest) |=>
			frameRateSetting == $past(idleRateSetting))
		else $error("idle frame rate not applied");
	a_reduced_pixel: assert property (@(posedge clk) disable iff (!rst_n)
		(scanValid && idleActive) |=>
			panelPixel.r == {6{$past(scanPixel.r[5])}} &&
			panelPixel.g == {6{$past(scanPixel.g[5])}} &&
			panelPixel.b == {6{$past(scanPixel.b[5])}})
		else $error("idle pixel not reduced to channel MSBs");
	a_full_pixel: assert property (@(posedge clk) disable iff (!rst_n)
		(scanValid && !idleActive) |=> panelPixel == $past(scanPixel))
		else $error("full colour pixel altered");
	a_format_store: assert property (@(posedge clk) disable iff (!rst_n)
		(paramTaken && state == idle_fmt_pkg::ST_WAIT_FORMAT) |=>
			videoFormat == $past(dataIn[7:4]) && !pixelFormat[3] &&
			controlFormat == $past(dataIn[2:0]))
		else $error("format parameter not stored");
	a_lvd_locked: assert property (@(posedge clk) disable iff (!rst_n)
		(paramTaken && state == idle_fmt_pkg::ST_WAIT_LVD && !unlocked) |=>
			$stable(lvdThreshold))
		else $error("threshold written while locked");
	a_lvd_store: assert property (@(posedge clk) disable iff (!rst_n)
		(paramTaken && state == idle_fmt_pkg::ST_WAIT_LVD && unlocked) |=>
			lvdThreshold == {6'h00, $past(dataIn[1:0])} ##1
			(lvdMillivolts == idle_fmt_pkg::LVD_MV_00) ==
			($past(dataIn[1:0], 2) == 2'h0))
		else $error("threshold not stored");
	a_lvd_decode: assert property (@(posedge clk) disable iff (!rst_n)
		(lvdThreshold[1:0] == 2'h1) |=> lvdMillivolts == idle_fmt_pkg::LVD_MV_01)
		else $error("threshold 01 not 2.0 V");
	a_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)
		s_sw_reset |=> pixelFormat == idle_fmt_pkg::PIXEL_FORMAT_RESET &&
			lvdThreshold == idle_fmt_pkg::LVD_RESET && !idleRequest)
		else $error("software reset defaults wrong");

endmodule

// ==== src/idle_fmt_pkg.sv ====
// Constants, types and codes shared by the idle and colour-format block.
// What this block does
// - Command 38h, no parameter, leaves idle mode for full colour display.
// - Idle off makes the timing generator use the normal frame rate.
// - Idle off while already idle off changes nothing.
// - Command 39h enters idle mode; command 38h, software reset 01h or rst_n leaves it.
// - Idle mode shows eight colours from each channel's MSB.
// - MSB map: none black, all white, one primary, two secondary.
// - Idle on makes the timing generator use the eight-colour frame rate.
// - Idle on while already idle on changes nothing.
// - Idle changes take effect without a visible glitch.
// - Command 3Ah takes one byte: video format 7:4, zero, control 2:0.
// - Video format 0101 16 bpp, 0110 18 bpp, 1110 18 bpp in three.
// - Control format 011 12 bpp, 101 16 bpp, 110 18 bpp.
// - 12 and 16 bpp pixels pass a lookup table into 18-bit memory.
// - Pixel format byte resets to 66h on every kind of reset.
// - Command 44h byte bits 1:0 pick the detect threshold; resets 02h.
// - Threshold 00 1.8 V, 01 2.0 V, 10 2.2 V, 11 2.4 V.
// - These commands are accepted in every operating state; here a 44h byte is ignored until the unlock key is written.
package idle_fmt_pkg;

	// Command codes
	localparam logic [7:0] CMD_SW_RESET = 8'h01;
	localparam logic [7:0] CMD_IDLE_OFF = 8'h38;
	localparam logic [7:0] CMD_IDLE_ON = 8'h39;
	localparam logic [7:0] CMD_PIXEL_FORMAT = 8'h3a;
	localparam logic [7:0] CMD_LVD = 8'h44;
	localparam logic [7:0] CMD_UNLOCK = 8'hff;
	localparam logic [7:0] UNLOCK_KEY = 8'ha5;

	// Reset values
	localparam logic [7:0] PIXEL_FORMAT_RESET = 8'h66;
	localparam logic [7:0] LVD_RESET = 8'h02;
	localparam logic IDLE_RESET = 1'b0;

	// Field positions inside the parameter bytes
	localparam int VIDEO_FMT_MSB = 7;
	localparam int VIDEO_FMT_LSB = 4;
	localparam int CTRL_FMT_MSB = 2;
	localparam int CTRL_FMT_LSB = 0;
	localparam int LVD_SEL_MSB = 1;
	localparam int LVD_SEL_LSB = 0;

	// Video port format codes
	localparam logic [3:0] VID_16_ONE = 4'h5;
	localparam logic [3:0] VID_18_ONE = 4'h6;
	localparam logic [3:0] VID_18_THREE = 4'he;

	// Control port format codes
	localparam logic [2:0] CTL_12 = 3'h3;
	localparam logic [2:0] CTL_16 = 3'h5;
	localparam logic [2:0] CTL_18 = 3'h6;

	// Detect thresholds in millivolts
	localparam logic [11:0] LVD_MV_00 = 12'h708;
	localparam logic [11:0] LVD_MV_01 = 12'h7d0;
	localparam logic [11:0] LVD_MV_10 = 12'h898;
	localparam logic [11:0] LVD_MV_11 = 12'h960;

	// Pixel geometry
	localparam int CHAN_BITS = 6;
	localparam int CHANNELS = 3;

	typedef enum logic [1:0] {
		ST_READY,
		ST_WAIT_FORMAT,
		ST_WAIT_LVD,
		ST_WAIT_KEY
	} cmd_state_t;

	typedef struct packed {
		logic [5:0] r;
		logic [5:0] g;
		logic [5:0] b;
	} pixel_t;

	typedef struct packed {
		logic known;
		logic [4:0] bitsPerPixel;
		logic [1:0] transfers;
	} fmt_info_t;

endpackage

// ==== src/pixel_expand.sv ====
// Host pixel expansion from the control-port format into 18-bit words.
`timescale 1ns/1ps
module pixel_expand
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Incoming host pixel
	input wire logic inValid,
	input wire logic [17:0] inData,
	input wire logic [2:0] controlFormat,
	// Frame memory word
	output logic outValid,
	output idle_fmt_pkg::pixel_t outPixel
);

	// Widen a 4-bit channel by repeating its top bits
	function automatic logic [5:0] lut4(input logic [3:0] v);
		lut4 = {v, v[3:2]};
	endfunction

	// Widen a 5-bit channel by repeating its MSB
	function automatic logic [5:0] lut5(input logic [4:0] v);
		lut5 = {v, v[4]};
	endfunction

	idle_fmt_pkg::pixel_t next_pixel;

	// Undefined codes fall back to raw 18-bit data rather than dropping
	always_comb
	begin
		next_pixel = inData;
		if (controlFormat == idle_fmt_pkg::CTL_12)
		begin
			next_pixel.r = lut4(inData[11:8]);
			next_pixel.g = lut4(inData[7:4]);
			next_pixel.b = lut4(inData[3:0]);
		end
		else if (controlFormat == idle_fmt_pkg::CTL_16)
		begin
			next_pixel.r = lut5(inData[15:11]);
			next_pixel.g = inData[10:5];
			next_pixel.b = lut5(inData[4:0]);
		end
	end

	// One register stage toward frame memory
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			outValid <= 1'b0;
			outPixel <= '0;
		end
		else
		begin
			outValid <= inValid;
			if (inValid)
			begin
				outPixel <= next_pixel;
			end
		end
	end

endmodule

// ==== dv/host_model.sv ====
// Host controller model that drives the byte-wide command port.
`timescale 1ns/1ps
module host_model
(
	// Clock
	input wire logic clk,
	// Command port
	output logic cmdParamSelect,
	output logic write_strobe_n,
	output logic [7:0] dataIn
);
	// Idle port levels from time zero
	initial
	begin
		cmdParamSelect = 1'b1;
		write_strobe_n = 1'b1;
		dataIn = 8'h00;
	end

	// Strobe low one cycle, high one cycle; afterwards the bus is scrambled
	// so that a late sample can never pick up a stale byte
	task automatic sendByte(input logic isParam, input logic [7:0] value);
		@(negedge clk);
		cmdParamSelect = isParam;
		dataIn = value;
		write_strobe_n = 1'b0;
		@(negedge clk);
		write_strobe_n = 1'b1;
		@(negedge clk);
		dataIn = ~value;
	endtask

	// Command byte with no parameter
	task automatic command(input logic [7:0] code);
		sendByte(1'b0, code);
	endtask

	// Command byte followed by its single parameter byte
	task automatic commandParam(input logic [7:0] code, input logic [7:0] p);
		sendByte(1'b0, code);
		sendByte(1'b1, p);
	endtask

	// Key write that must come before any detect threshold change
	task automatic unlock();
		commandParam(idle_fmt_pkg::CMD_UNLOCK, idle_fmt_pkg::UNLOCK_KEY);
	endtask
endmodule

// ==== dv/idle_color_format_lvd_cmds_bench.sv ====
// Self-checking bench for the idle, pixel format and detect commands.
`timescale 1ns/1ps
`define CHECK(got, exp) \
	begin \
		checks++; \
		if ((got) !== (exp)) \
		begin \
			num_errors++; \
			$display("[ERR] %0t got %h expected %h", $time, got, exp); \
		end \
	end
module idle_color_format_lvd_cmds_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmdParamSelect, write_strobe_n, frameStart, pixelInValid, scanValid;
	logic [7:0] dataIn, frameRateSetting, pixelFormat, lvdThreshold;
	logic [7:0] normalRate = 8'h1e;
	logic [7:0] idleRate = 8'h08;
	logic [17:0] pixelInData;
	logic idleActive, memWriteValid, panelValid, unlocked;
	logic [3:0] videoFormat;
	logic [2:0] controlFormat;
	logic [11:0] lvdMillivolts;
	idle_fmt_pkg::pixel_t memWriteData, scanPixel, panelPixel;
	idle_fmt_pkg::fmt_info_t videoInfo, controlInfo;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;
	// Format bytes, expected register and decoded infos
	logic [7:0] fmtIn [4] = '{8'h55, 8'h66, 8'he3, 8'h0f};
	logic [7:0] fmtExp [4] = '{8'h55, 8'h66, 8'he3, 8'h07};
	logic [7:0] vidExp [4] = '{8'hc1, 8'hc9, 8'hcb, 8'h00};
	logic [7:0] ctlExp [4] = '{8'hc1, 8'hc9, 8'hb1, 8'h00};
	// Host pixels per format and the expanded memory words
	logic [7:0] pixFmt [3] = '{8'he3, 8'h55, 8'h66};
	logic [17:0] pixIn [3] = '{18'h00f8c, 18'h08410, 18'h2c5a3};
	logic [17:0] pixExp [3] = '{18'h3f8b3, 18'h21821, 18'h2c5a3};
	logic [11:0] mvExp [4] = '{12'h708, 12'h7d0, 12'h898, 12'h960};

	// Clock
	always #25 clk = ~clk;

	host_model host (.clk(clk), .cmdParamSelect(cmdParamSelect),
		.write_strobe_n(write_strobe_n), .dataIn(dataIn));

	idle_color_format_lvd_cmds dut (.clk(clk), .rst_n(rst_n),
		.cmdParamSelect(cmdParamSelect), .write_strobe_n(write_strobe_n),
		.dataIn(dataIn), .frameStart(frameStart),
		.normalRateSetting(normalRate), .idleRateSetting(idleRate),
		.frameRateSetting(frameRateSetting), .idleActive(idleActive),
		.pixelInValid(pixelInValid), .pixelInData(pixelInData),
		.memWriteValid(memWriteValid), .memWriteData(memWriteData),
		.scanValid(scanValid), .scanPixel(scanPixel),
		.panelValid(panelValid), .panelPixel(panelPixel),
		.pixelFormat(pixelFormat), .videoFormat(videoFormat),
		.controlFormat(controlFormat), .videoInfo(videoInfo),
		.controlInfo(controlInfo), .lvdThreshold(lvdThreshold),
		.lvdMillivolts(lvdMillivolts), .unlocked(unlocked));

	// Verdict and end of run
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			num_errors++;
			$display("[ERR] %0t run did not finish", $time);
			close_out();
		end
	end

	// Decoded outputs trail a taken byte by one cycle
	task automatic settle();
		repeat (3) @(negedge clk);
	endtask

	// One frame boundary pulse, then let the change land
	task automatic frame();
		@(negedge clk);
		frameStart = 1'b1;
		@(negedge clk);
		frameStart = 1'b0;
		@(negedge clk);
	endtask

	// Host pixel in, single-cycle memory write out
	task automatic pixelWrite(input logic [17:0] d, input logic [17:0] exp);
		int n;
		@(negedge clk);
		pixelInData = d;
		pixelInValid = 1'b1;
		@(negedge clk);
		pixelInValid = 1'b0;
		n = 0;
		while (memWriteValid !== 1'b1 && n < 4)
		begin
			@(negedge clk);
			n++;
		end
		`CHECK(memWriteValid, 1'b1)
		`CHECK(memWriteData, exp)
		@(negedge clk);
		`CHECK(memWriteValid, 1'b0)
	endtask

	// Frame memory pixel in, panel pixel out
	task automatic scanCheck(input logic [17:0] d, input logic [17:0] exp);
		int n;
		@(negedge clk);
		scanPixel = d;
		scanValid = 1'b1;
		@(negedge clk);
		scanValid = 1'b0;
		n = 0;
		while (panelValid !== 1'b1 && n < 4)
		begin
			@(negedge clk);
			n++;
		end
		`CHECK(panelValid, 1'b1)
		`CHECK(panelPixel, exp)
	endtask

	// Main sequence
	initial
	begin
		frameStart = 1'b0;
		pixelInValid = 1'b0;
		pixelInData = 18'h00000;
		scanValid = 1'b0;
		scanPixel = 18'h00000;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		`CHECK(pixelFormat, 8'h66)
		`CHECK(lvdThreshold, 8'h02)
		`CHECK(lvdMillivolts, 12'h898)
		`CHECK(idleActive, 1'b0)
		`CHECK(videoInfo, 8'hc9)
		$display("Test reset values done");
		for (int i = 0; i < 4; i++)
		begin
			host.commandParam(idle_fmt_pkg::CMD_PIXEL_FORMAT, fmtIn[i]);
			settle();
			`CHECK(pixelFormat, fmtExp[i])
			`CHECK(videoFormat, fmtExp[i][7:4])
			`CHECK(controlFormat, fmtExp[i][2:0])
			`CHECK(videoInfo.known, vidExp[i][7])
			`CHECK(controlInfo.known, ctlExp[i][7])
			if (i < 3)
			begin
				`CHECK(videoInfo, vidExp[i])
				`CHECK(controlInfo, ctlExp[i])
			end
		end
		for (int i = 0; i < 3; i++)
		begin
			host.commandParam(idle_fmt_pkg::CMD_PIXEL_FORMAT, pixFmt[i]);
			settle();
			pixelWrite(pixIn[i], pixExp[i]);
		end
		$display("Test pixel formats done");
		frame();
		`CHECK(frameRateSetting, normalRate)
		host.command(idle_fmt_pkg::CMD_IDLE_ON);
		settle();
		`CHECK(idleActive, 1'b0)
		frame();
		`CHECK(idleActive, 1'b1)
		`CHECK(frameRateSetting, idleRate)
		// Low bits opposite to the MSB, so only the MSB may decide
		for (int i = 0; i < 8; i++)
			scanCheck({i[2], {5{~i[2]}}, i[1], {5{~i[1]}}, i[0], {5{~i[0]}}},
				{{6{i[2]}}, {6{i[1]}}, {6{i[0]}}});
		host.commandParam(idle_fmt_pkg::CMD_PIXEL_FORMAT, 8'h55);
		settle();
		`CHECK(pixelFormat, 8'h55)
		host.command(idle_fmt_pkg::CMD_IDLE_ON);
		frame();
		`CHECK(idleActive, 1'b1)
		host.command(idle_fmt_pkg::CMD_IDLE_OFF);
		frame();
		`CHECK(idleActive, 1'b0)
		`CHECK(frameRateSetting, normalRate)
		scanCheck(18'h2c5a3, 18'h2c5a3);
		host.command(idle_fmt_pkg::CMD_IDLE_OFF);
		frame();
		`CHECK(idleActive, 1'b0)
		$display("Test idle mode done");
		host.commandParam(idle_fmt_pkg::CMD_LVD, 8'h01);
		settle();
		`CHECK(lvdThreshold, 8'h02)
		host.unlock();
		settle();
		`CHECK(unlocked, 1'b1)
		for (int s = 0; s < 4; s++)
		begin
			host.commandParam(idle_fmt_pkg::CMD_LVD, {6'h3f, s[1:0]});
			settle();
			`CHECK(lvdThreshold, {6'h00, s[1:0]})
			`CHECK(lvdMillivolts, mvExp[s])
		end
		$display("Test detect threshold done");
		host.command(idle_fmt_pkg::CMD_IDLE_ON);
		frame();
		host.command(idle_fmt_pkg::CMD_SW_RESET);
		settle();
		`CHECK(pixelFormat, 8'h66)
		`CHECK(lvdThreshold, 8'h02)
		`CHECK(unlocked, 1'b0)
		frame();
		`CHECK(idleActive, 1'b0)
		host.commandParam(idle_fmt_pkg::CMD_PIXEL_FORMAT, 8'h55);
		settle();
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		`CHECK(pixelFormat, 8'h66)
		$display("Test resets done");
		close_out();
	end
endmodule
